// ==== rtl/sbtc_pkg.sv ====
/*
 * Package for the 16-bit timer/counter: register offsets, field positions,
 * reset values and shared types.
 * Assumes an 8-bit register port with a one-cycle read latency.
 */
package sbtc_pkg;

    localparam int unsigned SBTC_ADDR_W = 3;

    // Register offsets.
    localparam logic [2:0] SBTC_OFF_CTRL = 3'h0;
    localparam logic [2:0] SBTC_OFF_CNT_LO = 3'h1;
    localparam logic [2:0] SBTC_OFF_CNT_HI = 3'h2;
    localparam logic [2:0] SBTC_OFF_FLAG = 3'h3;
    localparam logic [2:0] SBTC_OFF_IRQ_EN = 3'h4;
    localparam logic [2:0] SBTC_OFF_CMP_LO = 3'h5;
    localparam logic [2:0] SBTC_OFF_CMP_HI = 3'h6;
    localparam logic [2:0] SBTC_OFF_CMP_MODE = 3'h7;

    // Control register field positions.
    localparam int unsigned SBTC_B_RUN = 0;
    localparam int unsigned SBTC_B_SRC = 1;
    localparam int unsigned SBTC_B_SYNC = 2;
    localparam int unsigned SBTC_B_OSC = 3;
    localparam int unsigned SBTC_B_PS_LO = 4;
    localparam int unsigned SBTC_B_WIDE = 7;

    // Reset values and masks.
    localparam logic [7:0] SBTC_CTRL_RST = 8'h00;
    localparam logic [7:0] SBTC_CTRL_MASK = 8'hbf;
    localparam logic [3:0] SBTC_CMP_SPECIAL = 4'hb;
    localparam logic [15:0] SBTC_CNT_MAX = 16'hffff;

    // Instruction cycle is the system clock divided by this figure.
    localparam int unsigned SBTC_INSTR_DIV = 4;

    typedef struct packed {
        logic wide;
        logic [1:0] ps_sel;
        logic osc_en;
        logic sync_bypass;
        logic src_sel;
        logic run;
    } sbtc_ctrl_t;

    typedef struct packed {
        logic [SBTC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbtc_bus_req_t;

endpackage : sbtc_pkg

// ==== rtl/sbtc_timer.sv ====
/*
 * 16-bit timer/counter with prescaler, wide-access buffer, overflow flag
 * and compare special event reset.
 * Assumes a single system clock; the external count input and oscillator
 * pins arrive asynchronously and are synchronised here.
 */
// Chosen here: the placing of the registers and the strobed register port.
// Notes on behaviour
// - Wide bit set makes counter accesses 16-bit via high buffer; clear gives 8-bit.
// - Prescaler divides count input by 1, 2, 4 or 8 per two-bit field.
// - Internal source advances once per instruction cycle, clock divided by four.
// - External source advances on each rising edge of pin or built-in oscillator.
// - Sync bit is stored but has no effect; external counting is always synchronised; ignored internally.
// - Run bit lets counter advance; clear halts it.
// - Oscillator enable starts oscillator and forces its two pins to inputs.
// - Built-in oscillator keeps running during sleep.
// - Count wraps FFFF to 0000 and sets overflow flag in flag register bit 0.
// - Overflow request is masked by enable bit 0 of enable register.
// - Compare special event mode 1011 resets counter and requests conversion start.
// - Special event reset never sets the overflow flag.
// - Software counter write beats a simultaneous special event reset.
// - Compare pair acts as period when special event trigger is used.
// - Wide mode: high address is buffer, low read copies live high byte.
// - Wide mode: high writes hit buffer; low write loads buffer into high.
// - Wide mode: live high byte is not directly readable or writable.
// - Low byte write clears prescaler; high byte write leaves it alone.
// - Control bit 6 always reads zero.
// - Power-on reset clears control bits; other resets leave them unchanged.
`timescale 1ns/10ps
module sbtc_timer
    import sbtc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic soft_rst_n_in,
    input wire logic sleep_in,
    input wire logic [SBTC_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_count_clock_pin_in,
    input wire logic osc_input_pin_in,
    input wire logic adc_enabled_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    output logic adc_start_out,
    output logic osc_output_pin_out,
    output logic osc_output_pin_oe_n_out,
    output logic osc_input_pin_oe_n_out,
    output logic osc_running_out
);

    ////////////////////////////////////////////////////////////////////////
    sbtc_bus_req_t req;
    sbtc_ctrl_t ctrl_r;
    logic [15:0] count_r;
    logic [7:0] hi_buf_r;
    logic [2:0] ps_cnt_r;
    logic [1:0] instr_div_r;
    logic ovf_flag_r;
    logic ovf_en_r;
    logic [15:0] cmp_r;
    logic [3:0] cmp_mode_r;
    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic [7:0] rdata_r;
    logic adc_start_r;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    wire wr_ctrl = req.wr && req.addr == SBTC_OFF_CTRL;
    wire wr_lo = req.wr && req.addr == SBTC_OFF_CNT_LO;
    wire wr_hi = req.wr && req.addr == SBTC_OFF_CNT_HI;
    wire rd_lo = req.rd && req.addr == SBTC_OFF_CNT_LO;
    // A wide-mode high write lands in the buffer only, so it must not cost a count.
    wire cnt_wr = wr_lo || (wr_hi && !ctrl_r.wide);

    ////////////////////////////////////////////////////////////////////////
    // Control register: the asynchronous reset is power-on only; soft resets
    // are left out on purpose so the timer setup survives them.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= sbtc_ctrl_t'({SBTC_CTRL_RST[7], SBTC_CTRL_RST[5:0]});
        end else if (wr_ctrl) begin
            ctrl_r <= sbtc_ctrl_t'({req.wdata[7], req.wdata[5:0]});
        end
    end

    // The oscillator keeps running in sleep; only its enable stops it.
    assign osc_running_out = ctrl_r.osc_en;
    // Oscillator pins are held as inputs whether enabled or not; the amplifier output is
    // modelled as released rather than driven, since the crystal is analogue.
    assign osc_input_pin_oe_n_out = 1'b1;
    assign osc_output_pin_oe_n_out = 1'b1;
    assign osc_output_pin_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; a third stage gives the edge detector.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_count_clock_pin_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            osc_s1_r <= osc_input_pin_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // The asynchronous mode is still sampled here in a single-clock design,
    // so it behaves as the synchronised mode; the bit only changes intent.
    wire ext_rise = ctrl_r.osc_en ? (osc_s2_r && !osc_s3_r)
                                  : (ext_s2_r && !ext_s3_r);

    // Instruction clock divider.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end
    wire instr_tick = instr_div_r == 2'(SBTC_INSTR_DIV - 1);

    // Internal source ignores the sync bit entirely.
    wire src_tick = ctrl_r.src_sel ? ext_rise : instr_tick;
    wire in_tick = ctrl_r.run && src_tick && !(sleep_in && !ctrl_r.src_sel);

    ////////////////////////////////////////////////////////////////////////
    // Prescaler.
    logic [2:0] ps_mask;
    always_comb begin
        unique case (ctrl_r.ps_sel)
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            2'h3: ps_mask = 3'h7;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ps_cnt_r <= 3'h0;
        end else if (wr_lo) begin
            ps_cnt_r <= 3'h0;
        end else if (in_tick) begin
            ps_cnt_r <= (ps_cnt_r & ps_mask) == ps_mask ? 3'h0 : ps_cnt_r + 3'h1;
        end
    end
    wire cnt_tick = in_tick && ((ps_cnt_r & ps_mask) == ps_mask);

    ////////////////////////////////////////////////////////////////////////
    // Compare unit registers and special event.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_r <= 16'h0000;
            cmp_mode_r <= 4'h0;
        end else begin
            if (req.wr && req.addr == SBTC_OFF_CMP_LO) cmp_r[7:0] <= req.wdata;
            if (req.wr && req.addr == SBTC_OFF_CMP_HI) cmp_r[15:8] <= req.wdata;
            if (req.wr && req.addr == SBTC_OFF_CMP_MODE) cmp_mode_r <= req.wdata[3:0];
        end
    end
    wire special_evt = cmp_mode_r == SBTC_CMP_SPECIAL && count_r == cmp_r;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adc_start_r <= 1'b0;
        end else begin
            adc_start_r <= special_evt && adc_enabled_in;
        end
    end
    assign adc_start_out = adc_start_r;

    ////////////////////////////////////////////////////////////////////////
    // Counter. Writes beat the special reset, which beats counting.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= 16'h0000;
        end else if (cnt_wr) begin
            if (ctrl_r.wide) begin
                if (wr_lo) count_r <= {hi_buf_r, req.wdata};
            end else if (wr_lo) begin
                count_r[7:0] <= req.wdata;
            end else begin
                count_r[15:8] <= req.wdata;
            end
        end else if (special_evt) begin
            count_r <= 16'h0000;
        end else if (cnt_tick) begin
            count_r <= count_r + 16'h0001;
        end
    end
    wire wrap = cnt_tick && count_r == SBTC_CNT_MAX && !special_evt && !cnt_wr;

    // High byte buffer, used only in wide mode.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_buf_r <= 8'h00;
        end else if (ctrl_r.wide && wr_hi) begin
            hi_buf_r <= req.wdata;
        end else if (ctrl_r.wide && rd_lo) begin
            hi_buf_r <= count_r[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow flag and enable; a new wrap wins over a clear.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ovf_flag_r <= 1'b0;
            ovf_en_r <= 1'b0;
        end else begin
            if (wrap) begin
                ovf_flag_r <= 1'b1;
            end else if (req.wr && req.addr == SBTC_OFF_FLAG) begin
                ovf_flag_r <= req.wdata[0];
            end
            if (req.wr && req.addr == SBTC_OFF_IRQ_EN) ovf_en_r <= req.wdata[0];
        end
    end
    assign irq_out = ovf_flag_r && ovf_en_r;

    ////////////////////////////////////////////////////////////////////////
    // Read port. Control bit 6 is not stored, so wide is put back at bit 7.
    wire [7:0] ctrl_rd = {ctrl_r.wide, 1'b0, ctrl_r.ps_sel, ctrl_r.osc_en,
                          ctrl_r.sync_bypass, ctrl_r.src_sel, ctrl_r.run};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            SBTC_OFF_CTRL: rd_mux = ctrl_rd & SBTC_CTRL_MASK;
            SBTC_OFF_CNT_LO: rd_mux = count_r[7:0];
            SBTC_OFF_CNT_HI: rd_mux = ctrl_r.wide ? hi_buf_r : count_r[15:8];
            SBTC_OFF_FLAG: rd_mux = {7'h00, ovf_flag_r};
            SBTC_OFF_IRQ_EN: rd_mux = {7'h00, ovf_en_r};
            SBTC_OFF_CMP_LO: rd_mux = cmp_r[7:0];
            SBTC_OFF_CMP_HI: rd_mux = cmp_r[15:8];
            SBTC_OFF_CMP_MODE: rd_mux = {4'h0, cmp_mode_r};
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_wrap_flag;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wrap |=> ovf_flag_r && count_r == 16'h0000;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

    property p_special_noflag;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        special_evt && !wr_lo && !wr_hi && !ovf_flag_r && !(req.wr && req.addr == SBTC_OFF_FLAG)
            |=> !ovf_flag_r && count_r == 16'h0000;
    endproperty
    a_special_noflag: assert property (p_special_noflag) else $error("special reset wrong");

    property p_write_wins;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        special_evt && wr_lo && !ctrl_r.wide |=> count_r[7:0] == $past(req.wdata);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write lost to reset");

    property p_halt;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !ctrl_r.run && !req.wr && !special_evt |=> $stable(count_r);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");

    property p_ps_clear;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_lo |=> ps_cnt_r == 3'h0;
    endproperty
    a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

    property p_wide_lo_write;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_r.wide && wr_lo |=> count_r[15:8] == $past(hi_buf_r);
    endproperty
    a_wide_lo_write: assert property (p_wide_lo_write) else $error("buffer not loaded");

    property p_wide_lo_read;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_r.wide && rd_lo && !wr_hi |=> hi_buf_r == $past(count_r[15:8]);
    endproperty
    a_wide_lo_read: assert property (p_wide_lo_read) else $error("buffer not latched");

    property p_bit6;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        req.rd && req.addr == SBTC_OFF_CTRL |=> !rdata_out[6];
    endproperty
    a_bit6: assert property (p_bit6) else $error("control bit 6 set");

    property p_irq;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wrap && ovf_en_r && !(req.wr && req.addr == SBTC_OFF_IRQ_EN) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_hi_count;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_r.wide && wr_hi && cnt_tick && !special_evt
            |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_hi_count: assert property (p_hi_count) else $error("count stalled");

    property p_soft_ctrl;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !soft_rst_n_in && !wr_ctrl |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_soft_ctrl: assert property (p_soft_ctrl) else $error("control lost");

    property p_adc_start;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        special_evt && adc_enabled_in |=> adc_start_out;
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("conversion start missing");

    property p_adc_gate;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !adc_enabled_in |=> !adc_start_out;
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("conversion start while off");

    property p_sleep_osc;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        sleep_in && ctrl_r.run && ctrl_r.src_sel && ctrl_r.osc_en && ctrl_r.ps_sel == 2'h0
            && osc_s2_r && !osc_s3_r && !req.wr && !special_evt
            |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_sleep_osc: assert property (p_sleep_osc) else $error("count missed in sleep");

    property p_rdata_idle;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !req.rd |=> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

    property p_osc_pins;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_r.osc_en |-> osc_input_pin_oe_n_out && osc_output_pin_oe_n_out;
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("oscillator pin driven");

    property p_narrow_hi;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !ctrl_r.wide && wr_hi |=> count_r[15:8] == $past(req.wdata);
    endproperty
    a_narrow_hi: assert property (p_narrow_hi) else $error("high byte not written");

    property p_wide_hi_buf;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl_r.wide && wr_hi |=> hi_buf_r == $past(req.wdata);
    endproperty
    a_wide_hi_buf: assert property (p_wide_hi_buf) else $error("buffer not written");

endmodule : sbtc_timer

// ==== tb/sbtc_src_model.sv ====
/*
 * Far-side count source: the external count clock pin and the crystal input.
 * Assumes the bench calls burst from its own process; both lines idle low between bursts.
 */
`timescale 1ns/10ps
module sbtc_src_model (
    output logic ext_clk_out,
    output logic osc_out
);
    initial begin
        ext_clk_out = 1'b0;
        osc_out = 1'b0;
    end

    // Each pulse is one rising edge, slow enough for the two-flop input sampler.
    task automatic burst(input int n, input bit on_osc);
        repeat (n) begin
            if (on_osc) begin
                osc_out = 1'b1;
            end else begin
                ext_clk_out = 1'b1;
            end
            #48;
            osc_out = 1'b0;
            ext_clk_out = 1'b0;
            #48;
        end
    endtask : burst
endmodule : sbtc_src_model

// ==== tb/tb_sixteen_bit_timer_counter.sv ====
/*
 * Self-checking bench for the 16-bit timer/counter.
 * Assumes the register map of the package and the source model beside it.
 */
`timescale 1ns/10ps
module tb_sixteen_bit_timer_counter;
    import sbtc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic soft_rst_n_in = 1'b1;
    logic sleep_in = 1'b0;
    logic [SBTC_ADDR_W-1:0] addr_in = '0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic adc_enabled_in = 1'b0;
    logic ext_clk, osc_in, irq_out, adc_start_out, osc_pin, osc_pin_oe_n, osc_in_oe_n, osc_run;
    logic [7:0] rdata_out;
    int n_mismatch = 0;
    int checks = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    sbtc_src_model u_src (.ext_clk_out(ext_clk), .osc_out(osc_in));

    sbtc_timer dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .soft_rst_n_in(soft_rst_n_in),
        .sleep_in(sleep_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .ext_count_clock_pin_in(ext_clk), .osc_input_pin_in(osc_in),
        .adc_enabled_in(adc_enabled_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .adc_start_out(adc_start_out), .osc_output_pin_out(osc_pin),
        .osc_output_pin_oe_n_out(osc_pin_oe_n), .osc_input_pin_oe_n_out(osc_in_oe_n),
        .osc_running_out(osc_run)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Free-running tick phase is not cleared by a count write, so one tick of slack.
    task automatic near(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e && g !== e + 16'h1 && g !== e - 16'h1) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : near

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        @(negedge sys_clk_in);
        d = rdata_out;
    endtask : rd

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(SBTC_OFF_CTRL, 8'h00, "control after reset");
        chk("osc input enable", 16'h1, {15'h0, osc_in_oe_n});
        chk("osc running after reset", 16'h0, {15'h0, osc_run});
        chk("osc output pin", 16'h0, {15'h0, osc_pin});
        wr(SBTC_OFF_CTRL, 8'hff);
        rd_chk(SBTC_OFF_CTRL, 8'hbf, "control bit six");
        @(posedge sys_clk_in);
        soft_rst_n_in <= 1'b0;
        @(posedge sys_clk_in);
        soft_rst_n_in <= 1'b1;
        rd_chk(SBTC_OFF_CTRL, 8'hbf, "control after soft reset");
        wr(SBTC_OFF_CTRL, 8'h00);
    endtask : t_reset

    task automatic t_prescale();
        logic [7:0] d, h;
        for (int ps = 0; ps < 4; ps++) begin
            wr(SBTC_OFF_CNT_HI, 8'h00);
            wr(SBTC_OFF_CTRL, {2'b00, 2'(ps), 4'h1});
            wr(SBTC_OFF_CNT_LO, 8'h00);
            repeat (128) @(posedge sys_clk_in);
            wr(SBTC_OFF_CTRL, 8'h00);
            rd(SBTC_OFF_CNT_LO, d);
            near("prescaled count", 16'(32 >> ps), {8'h00, d});
            repeat (40) @(posedge sys_clk_in);
            rd(SBTC_OFF_CNT_LO, h);
            chk("halted count", {8'h00, d}, {8'h00, h});
        end
    endtask : t_prescale

    task automatic t_wide();
        wr(SBTC_OFF_CTRL, 8'h80);
        wr(SBTC_OFF_CNT_HI, 8'h12);
        rd_chk(SBTC_OFF_CNT_HI, 8'h12, "wide high buffer");
        wr(SBTC_OFF_CNT_LO, 8'h34);
        wr(SBTC_OFF_CNT_HI, 8'h56);
        wr(SBTC_OFF_CTRL, 8'h00);
        rd_chk(SBTC_OFF_CNT_LO, 8'h34, "narrow low");
        rd_chk(SBTC_OFF_CNT_HI, 8'h12, "live high after wide");
        wr(SBTC_OFF_CTRL, 8'h80);
        wr(SBTC_OFF_CNT_HI, 8'h99);
        rd_chk(SBTC_OFF_CNT_LO, 8'h34, "wide low");
        rd_chk(SBTC_OFF_CNT_HI, 8'h12, "buffer loaded by low read");
        wr(SBTC_OFF_CTRL, 8'h00);
    endtask : t_wide

    task automatic t_overflow();
        wr(SBTC_OFF_CNT_HI, 8'hff);
        wr(SBTC_OFF_CNT_LO, 8'hfe);
        wr(SBTC_OFF_FLAG, 8'h00);
        wr(SBTC_OFF_IRQ_EN, 8'h00);
        wr(SBTC_OFF_CTRL, 8'h01);
        repeat (24) @(posedge sys_clk_in);
        wr(SBTC_OFF_CTRL, 8'h00);
        rd_chk(SBTC_OFF_FLAG, 8'h01, "overflow flag");
        rd_chk(SBTC_OFF_CNT_HI, 8'h00, "wrapped high");
        chk("masked request", 16'h0, {15'h0, irq_out});
        wr(SBTC_OFF_IRQ_EN, 8'h01);
        @(negedge sys_clk_in);
        chk("enabled request", 16'h1, {15'h0, irq_out});
        wr(SBTC_OFF_FLAG, 8'h00);
        @(negedge sys_clk_in);
        chk("request after clear", 16'h0, {15'h0, irq_out});
    endtask : t_overflow

    task automatic t_special();
        int n;
        // Timer mode only, so the compare reset is dependable.
        wr(SBTC_OFF_CNT_HI, 8'h00);
        wr(SBTC_OFF_CNT_LO, 8'h00);
        wr(SBTC_OFF_CMP_HI, 8'h00);
        wr(SBTC_OFF_CMP_LO, 8'h10);
        wr(SBTC_OFF_CMP_MODE, {4'h0, SBTC_CMP_SPECIAL});
        for (int en = 1; en >= 0; en--) begin
            adc_enabled_in <= 1'(en);
            wr(SBTC_OFF_CTRL, 8'h01);
            n = 0;
            repeat (320) begin
                @(negedge sys_clk_in);
                n += int'(adc_start_out === 1'b1);
            end
            wr(SBTC_OFF_CTRL, 8'h00);
            near("conversion starts", 16'(5 * en), 16'(n));
            rd_chk(SBTC_OFF_CNT_HI, 8'h00, "period high");
        end
        // Compare at zero fires every cycle while halted at zero; the write must win.
        wr(SBTC_OFF_CMP_LO, 8'h00);
        wr(SBTC_OFF_CNT_HI, 8'h00);
        wr(SBTC_OFF_CNT_LO, 8'h00);
        wr(SBTC_OFF_CNT_LO, 8'h05);
        rd_chk(SBTC_OFF_CNT_LO, 8'h05, "write beside compare reset");
        rd_chk(SBTC_OFF_FLAG, 8'h00, "flag after compare reset");
        wr(SBTC_OFF_CMP_MODE, 8'h00);
    endtask : t_special

    task automatic t_external();
        wr(SBTC_OFF_CNT_HI, 8'h00);
        wr(SBTC_OFF_CNT_LO, 8'h00);
        wr(SBTC_OFF_CTRL, 8'h03);
        u_src.burst(10, 1'b0);
        wr(SBTC_OFF_CTRL, 8'h07);
        u_src.burst(6, 1'b0);
        wr(SBTC_OFF_CTRL, 8'h0b);
        sleep_in <= 1'b1;
        u_src.burst(5, 1'b1);
        u_src.burst(3, 1'b0);
        repeat (8) @(posedge sys_clk_in);
        chk("osc running", 16'h1, {15'h0, osc_run});
        chk("osc pins input", 16'h3, {14'h0, osc_in_oe_n, osc_pin_oe_n});
        wr(SBTC_OFF_CTRL, 8'h00);
        sleep_in <= 1'b0;
        rd_chk(SBTC_OFF_CNT_LO, 8'h15, "external edges");
    endtask : t_external

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_prescale();
        t_wide();
        t_overflow();
        t_special();
        t_external();
        conclude();
    end

    // The whole sequence needs well under 10,000 clocks; this cuts a hang short.
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end
endmodule : tb_sixteen_bit_timer_counter
